/* File: design/cct_timer.sv */
`timescale 1ns/1ps
`include "cct_map.svh"
module cct_timer #(
    parameter int ADDR_W = 8
) (
    input  wire logic              mclk_in,
    input  wire logic              rst_n_in,
    input  wire logic              por_n_in,
    input  wire logic              stop_in,
    input  wire logic              capture_in_pin_in,
    output logic                   compare_out_pin_out,
    output logic                   irq_out,
    input  wire logic [ADDR_W-1:0] paddr_in,
    input  wire logic              psel_in,
    input  wire logic              penable_in,
    input  wire logic              pwrite_in,
    input  wire logic [31:0]       pwdata_in,
    output logic [31:0]            prdata_out,
    output logic                   pready_out,
    output logic                   pslverr_out
);

    // index 0x1b needs seven address bits; more than ten would alias the decode
    if (ADDR_W < 7 || ADDR_W > 10)
    begin : g_addr_check
        $error("cct_timer: ADDR_W must lie between 7 and 10");
    end

    cct_pkg::cct_state_type state_reg;
    cct_pkg::cct_state_type state_next;

    logic [7:0] word_idx;
    logic       access;
    logic       rd;
    logic       wr;
    logic       tick;
    logic       cap_edge;
    logic       counting;
    logic [7:0] ctrl_byte;
    logic [7:0] stat_byte;

    // word index of the byte address; low two bits ignored, words are aligned
    assign word_idx = 8'(paddr_in[ADDR_W-1:2]);

    // side effects happen once, in the access cycle before pready rises
    // the registered pready masks the completing cycle, so nothing happens twice
    assign access = psel_in && penable_in && !state_reg.ready;
    assign rd     = access && !pwrite_in;
    assign wr     = access && pwrite_in;

    // prescaler terminal count; counter and comparator both act on it
    // stop holds counter and comparator; the prescaler phase restarts on wake
    assign counting = !stop_in;
    assign tick     = counting && (state_reg.prescale == `CCT_PRESCALE_LAST);

    // edge taken from second and third stages only, never the first
    assign cap_edge = state_reg.edge_sel ? (state_reg.sync_second && !state_reg.sync_prev)
                                         : (!state_reg.sync_second && state_reg.sync_prev);

    // read views of control and status bytes
    always_comb
    begin
        ctrl_byte = 8'h00;
        ctrl_byte[`CCT_CTRL_CAP_IE]    = state_reg.cap_ie;
        ctrl_byte[`CCT_CTRL_CMP_IE]    = state_reg.cmp_ie;
        ctrl_byte[`CCT_CTRL_OVF_IE]    = state_reg.ovf_ie;
        ctrl_byte[`CCT_CTRL_EDGE_SEL]  = state_reg.edge_sel;
        ctrl_byte[`CCT_CTRL_OUT_LEVEL] = state_reg.out_level;
        stat_byte = 8'h00;
        stat_byte[`CCT_STAT_CAP_FLAG]  = state_reg.cap_flag;
        stat_byte[`CCT_STAT_CMP_FLAG]  = state_reg.cmp_flag;
        stat_byte[`CCT_STAT_OVF_FLAG]  = state_reg.ovf_flag;
    end

    // next state: bus effects first, then hardware events so a set beats a clear
    always_comb
    begin
        state_next = state_reg;

        // capture pin synchroniser and previous-sample stage
        // only the second and previous-sample stages are read; the first may still be settling
        state_next.sync_first  = capture_in_pin_in;
        state_next.sync_second = state_reg.sync_first;
        state_next.sync_prev   = state_reg.sync_second;
        state_next.stop_prev   = stop_in;

        // apb answer: one wait state, pready for exactly one cycle
        state_next.ready  = access;
        state_next.slverr = 1'b0;
        state_next.rdata  = 32'h0000_0000;

        if (rd)
        begin
            case (word_idx)
                // control byte reads back as written; unused bits read zero
                `CCT_IDX_CTRL:
                begin
                    state_next.rdata = {24'h00_0000, ctrl_byte};
                end
                `CCT_IDX_STATUS:
                begin
                    // a status read arms clearing of each flag that is set now
                    state_next.rdata         = {24'h00_0000, stat_byte};
                    state_next.cap_clr_armed = state_reg.cap_flag;
                    state_next.cmp_clr_armed = state_reg.cmp_flag;
                    state_next.ovf_clr_armed = state_reg.ovf_flag;
                end
                // high byte first; edge captures hold off, but a wake from stop still moves stop_cap_val into cap_val
                `CCT_IDX_CAP_HIGH:
                begin
                    state_next.rdata       = {24'h00_0000, state_reg.cap_val[15:8]};
                    state_next.cap_inhibit = 1'b1;
                end
                // low byte ends the pair and, once armed, clears the capture flag
                `CCT_IDX_CAP_LOW:
                begin
                    state_next.rdata       = {24'h00_0000, state_reg.cap_val[7:0]};
                    state_next.cap_inhibit = 1'b0;
                    if (state_reg.cap_clr_armed)
                    begin
                        state_next.cap_flag      = 1'b0;
                        state_next.cap_clr_armed = 1'b0;
                    end
                end
                // compare bytes read back freely; a high read sets no inhibit
                `CCT_IDX_CMP_HIGH:
                begin
                    state_next.rdata = {24'h00_0000, state_reg.cmp_val[15:8]};
                end
                // a low byte read clears an armed compare flag, as a write does
                `CCT_IDX_CMP_LOW:
                begin
                    state_next.rdata = {24'h00_0000, state_reg.cmp_val[7:0]};
                    if (state_reg.cmp_clr_armed)
                    begin
                        state_next.cmp_flag      = 1'b0;
                        state_next.cmp_clr_armed = 1'b0;
                    end
                end
                `CCT_IDX_CNT_HIGH:
                begin
                    // freeze the low byte so the pair reads as one value
                    state_next.rdata       = {24'h00_0000, state_reg.count[15:8]};
                    state_next.cnt_buf     = state_reg.count[7:0];
                    state_next.cnt_latched = 1'b1;
                end
                `CCT_IDX_CNT_LOW:
                begin
                    // latched byte after a high read, live byte otherwise
                    if (state_reg.cnt_latched)
                    begin
                        state_next.rdata = {24'h00_0000, state_reg.cnt_buf};
                    end
                    else
                    begin
                        state_next.rdata = {24'h00_0000, state_reg.count[7:0]};
                    end
                    state_next.cnt_latched = 1'b0;
                    if (state_reg.ovf_clr_armed)
                    begin
                        state_next.ovf_flag      = 1'b0;
                        state_next.ovf_clr_armed = 1'b0;
                    end
                end
                // own latch, so the two read paths never disturb each other
                `CCT_IDX_ALT_HIGH:
                begin
                    state_next.rdata       = {24'h00_0000, state_reg.count[15:8]};
                    state_next.alt_buf     = state_reg.count[7:0];
                    state_next.alt_latched = 1'b1;
                end
                `CCT_IDX_ALT_LOW:
                begin
                    // no effect on the overflow flag or its armed clear
                    if (state_reg.alt_latched)
                    begin
                        state_next.rdata = {24'h00_0000, state_reg.alt_buf};
                    end
                    else
                    begin
                        state_next.rdata = {24'h00_0000, state_reg.count[7:0]};
                    end
                    state_next.alt_latched = 1'b0;
                end
                // unmapped word: refused, nothing changes
                default:
                begin
                    state_next.slverr = 1'b1;
                end
            endcase
        end

        if (wr)
        begin
            case (word_idx)
                // all five control bits land together
                `CCT_IDX_CTRL:
                begin
                    state_next.cap_ie    = pwdata_in[`CCT_CTRL_CAP_IE];
                    state_next.cmp_ie    = pwdata_in[`CCT_CTRL_CMP_IE];
                    state_next.ovf_ie    = pwdata_in[`CCT_CTRL_OVF_IE];
                    state_next.edge_sel  = pwdata_in[`CCT_CTRL_EDGE_SEL];
                    state_next.out_level = pwdata_in[`CCT_CTRL_OUT_LEVEL];
                end
                // a half-new value could match early; hold compares off
                `CCT_IDX_CMP_HIGH:
                begin
                    state_next.cmp_val[15:8] = pwdata_in[7:0];
                    state_next.cmp_inhibit   = 1'b1;
                end
                // low byte completes the value and re-enables compares
                `CCT_IDX_CMP_LOW:
                begin
                    state_next.cmp_val[7:0] = pwdata_in[7:0];
                    state_next.cmp_inhibit  = 1'b0;
                    if (state_reg.cmp_clr_armed)
                    begin
                        state_next.cmp_flag      = 1'b0;
                        state_next.cmp_clr_armed = 1'b0;
                    end
                end
                // counter, capture and status words are read only
                `CCT_IDX_STATUS, `CCT_IDX_CAP_HIGH, `CCT_IDX_CAP_LOW,
                `CCT_IDX_CNT_HIGH, `CCT_IDX_CNT_LOW, `CCT_IDX_ALT_HIGH, `CCT_IDX_ALT_LOW:
                begin
                    state_next.slverr = 1'b0;
                end
                // unmapped word: refused
                default:
                begin
                    state_next.slverr = 1'b1;
                end
            endcase
        end

        // prescaler is held cleared while stopped
        // so a wake-up starts a fresh divide-by-four phase
        if (counting)
        begin
            state_next.prescale = state_reg.prescale + 2'h1;
        end
        else
        begin
            state_next.prescale = 2'h0;
        end

        // counter and comparator act once every fourth clock
        // stopped: neither counter nor comparator moves
        if (tick)
        begin
            state_next.count = state_reg.count + 16'h0001;
            // wrap from the top count to zero
            if (state_reg.count == `CCT_COUNT_MAX)
            begin
                state_next.ovf_flag = 1'b1;
            end
            // comparator sees the count before this increment
            if (!state_reg.cmp_inhibit && (state_reg.count == state_reg.cmp_val))
            begin
                state_next.cmp_pin  = state_reg.out_level;
                state_next.cmp_flag = 1'b1;
            end
        end

        // capture: live when running, only armed while stopped
        if (cap_edge && !state_reg.cap_inhibit)
        begin
            if (counting)
            begin
                state_next.cap_val  = state_reg.count;
                state_next.cap_flag = 1'b1;
            end
            else if (!state_reg.stop_edge_seen)
            begin
                // first edge in stop is held aside; later ones are dropped until the stop ends
                // a reset exit must leave no capture data, so cap_val stays untouched here
                state_next.stop_cap_val   = state_reg.count;
                state_next.stop_edge_seen = 1'b1;
            end
        end

        // leaving stop without reset means an interrupt woke us; count is kept
        if (rst_n_in && por_n_in && state_reg.stop_prev && !stop_in && state_reg.stop_edge_seen)
        begin
            state_next.cap_val        = state_reg.stop_cap_val;
            state_next.cap_flag       = 1'b1;
            state_next.stop_edge_seen = 1'b0;
        end

        // system reset: control, counter, compare pin and pending bus and clear state; flags and edge select kept
        if (!rst_n_in || !por_n_in)
        begin
            state_next.prescale       = 2'h0;
            state_next.count          = `CCT_COUNT_RESET;
            state_next.cnt_latched    = 1'b0;
            state_next.alt_latched    = 1'b0;
            state_next.cap_inhibit    = 1'b0;
            state_next.cmp_inhibit    = 1'b0;
            state_next.cap_ie         = 1'b0;
            state_next.cmp_ie         = 1'b0;
            state_next.ovf_ie         = 1'b0;
            state_next.out_level      = 1'b0;
            state_next.cap_clr_armed  = 1'b0;
            state_next.cmp_clr_armed  = 1'b0;
            state_next.ovf_clr_armed  = 1'b0;
            // an armed stop capture dies with reset; stop_cap_val is cleared only at power-on
            state_next.stop_edge_seen = 1'b0;
            state_next.stop_prev      = 1'b0;
            state_next.cmp_pin        = 1'b0;
            // no bus answer is left standing across a reset
            state_next.ready          = 1'b0;
            state_next.slverr         = 1'b0;
            state_next.rdata          = 32'h0000_0000;
        end

        // power-on only: gives flags and edge select a defined start value
        if (!por_n_in)
        begin
            state_next.cap_flag    = 1'b0;
            state_next.cmp_flag    = 1'b0;
            state_next.ovf_flag    = 1'b0;
            state_next.edge_sel    = 1'b0;
            state_next.cap_val     = 16'h0000;
            state_next.stop_cap_val = 16'h0000;
            state_next.cmp_val     = 16'h0000;
            state_next.cnt_buf     = 8'h00;
            state_next.alt_buf     = 8'h00;
            state_next.sync_first  = 1'b0;
            state_next.sync_second = 1'b0;
            state_next.sync_prev   = 1'b0;
        end

        // built from the next state so irq_out moves on the same edge as its flag
        // single request from any enabled flag, from the next state
        state_next.irq = (state_next.cap_flag && state_next.cap_ie) ||
                         (state_next.cmp_flag && state_next.cmp_ie) ||
                         (state_next.ovf_flag && state_next.ovf_ie);
    end

    // the one state register; reset is folded into the next-state logic
    always_ff @(posedge mclk_in)
    begin
        state_reg <= state_next;
    end

    // every output straight from the state register
    assign compare_out_pin_out = state_reg.cmp_pin;
    assign irq_out             = state_reg.irq;
    assign prdata_out          = state_reg.rdata;
    assign pready_out          = state_reg.ready;
    assign pslverr_out         = state_reg.slverr;

endmodule : cct_timer

/* File: shared/cct_map.svh */
`ifndef CCT_MAP_SVH
`define CCT_MAP_SVH

// register word indices; byte address is four times the index
`define CCT_IDX_CTRL        8'h12
`define CCT_IDX_STATUS      8'h13
`define CCT_IDX_CAP_HIGH    8'h14
`define CCT_IDX_CAP_LOW     8'h15
`define CCT_IDX_CMP_HIGH    8'h16
`define CCT_IDX_CMP_LOW     8'h17
`define CCT_IDX_CNT_HIGH    8'h18
`define CCT_IDX_CNT_LOW     8'h19
`define CCT_IDX_ALT_HIGH    8'h1a
`define CCT_IDX_ALT_LOW     8'h1b

// timer_control bit positions
`define CCT_CTRL_CAP_IE     7
`define CCT_CTRL_CMP_IE     6
`define CCT_CTRL_OVF_IE     5
`define CCT_CTRL_EDGE_SEL   1
`define CCT_CTRL_OUT_LEVEL  0

// timer_status bit positions
`define CCT_STAT_CAP_FLAG   7
`define CCT_STAT_CMP_FLAG   6
`define CCT_STAT_OVF_FLAG   5

// counter constants
`define CCT_PRESCALE_LAST   2'h3
`define CCT_COUNT_RESET     16'hfffc
`define CCT_COUNT_MAX       16'hffff
`define CCT_COUNT_ZERO      16'h0000

`endif

/* File: shared/cct_pkg.sv */
package cct_pkg;

    // whole state of the timer, registered as one word
    typedef struct packed {
        logic [1:0]  prescale;
        logic [15:0] count;
        logic [15:0] cap_val;
        logic [15:0] stop_cap_val;
        logic [15:0] cmp_val;
        logic [7:0]  cnt_buf;
        logic        cnt_latched;
        logic [7:0]  alt_buf;
        logic        alt_latched;
        logic        cap_inhibit;
        logic        cmp_inhibit;
        logic        cap_ie;
        logic        cmp_ie;
        logic        ovf_ie;
        logic        edge_sel;
        logic        out_level;
        logic        cap_flag;
        logic        cmp_flag;
        logic        ovf_flag;
        logic        cap_clr_armed;
        logic        cmp_clr_armed;
        logic        ovf_clr_armed;
        logic        sync_first;
        logic        sync_second;
        logic        sync_prev;
        logic        stop_prev;
        logic        stop_edge_seen;
        logic        cmp_pin;
        logic        irq;
        logic [31:0] rdata;
        logic        ready;
        logic        slverr;
    } cct_state_type;

endpackage : cct_pkg

/* File: tb/cct_pin_model.sv */
`timescale 1ns/1ps
// far side of the pins: a level source on capture, a load counting compare changes
module cct_pin_model (
    input  wire logic  mclk_in,
    input  wire logic  level_in,
    input  wire logic  compare_pin_in,
    output logic       capture_pin_out,
    output logic [7:0] toggles_out
);
    logic       last_pin = 1'b0;
    logic       cap_q    = 1'b0;
    logic [7:0] count_q  = 8'h00;

    // source moves just after an edge; load counts every change of the pin
    always @(posedge mclk_in)
    begin
        cap_q <= level_in;
        last_pin <= compare_pin_in;
        if (compare_pin_in !== last_pin)
            count_q <= count_q + 8'h01;
    end

    assign capture_pin_out = cap_q;
    assign toggles_out     = count_q;
endmodule : cct_pin_model

/* File: tb/cct_timer_checker.sv */
`timescale 1ns/1ps
// port-level watcher for the timer; sees only what the top module shows
module cct_timer_checker #(
    parameter int ADDR_W = 8
) (
    input wire logic              mclk_in,
    input wire logic              rst_n_in,
    input wire logic              por_n_in,
    input wire logic              stop_in,
    input wire logic              compare_out_pin_out,
    input wire logic              irq_out,
    input wire logic [ADDR_W-1:0] paddr_in,
    input wire logic              psel_in,
    input wire logic              penable_in,
    input wire logic [31:0]       prdata_out,
    input wire logic              pready_out,
    input wire logic              pslverr_out
);
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (!rst_n_in || !por_n_in);

    // word index outside the mapped window
    logic unmapped;
    assign unmapped = (paddr_in[ADDR_W-1:2] < 'h12) || (paddr_in[ADDR_W-1:2] > 'h1b);

    // first access cycle, where the slave takes the request
    sequence s_taken;
        psel_in && penable_in && !pready_out;
    endsequence
    sequence s_held_stop;
        stop_in ##1 stop_in;
    endsequence

    chk_ready_wait: assert property (s_taken |=> pready_out)
        else $error("pready late after taken access");
    chk_ready_pulse: assert property (pready_out |=> !pready_out)
        else $error("pready stood longer than one cycle");
    chk_ready_qual: assert property (pready_out |-> psel_in && penable_in)
        else $error("pready outside an access");
    chk_rdata_upper: assert property (pready_out |-> prdata_out[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    chk_err_unmapped: assert property (s_taken ##0 unmapped |=> pslverr_out)
        else $error("unmapped access not refused");
    chk_err_mapped: assert property (s_taken ##0 !unmapped |=> !pslverr_out)
        else $error("mapped access refused");
    chk_stop_pin: assert property (s_held_stop |-> $stable(compare_out_pin_out))
        else $error("compare pin moved while stopped");
    // reset clears enables and level, so neither output may stand high
    chk_reset_quiet: assert property (disable iff (!por_n_in)
        !rst_n_in ##1 !rst_n_in |-> !compare_out_pin_out && !irq_out)
        else $error("outputs high during reset");
endmodule : cct_timer_checker

bind cct_timer cct_timer_checker #(.ADDR_W(ADDR_W)) u_cct_timer_checker (
    .mclk_in(mclk_in), .rst_n_in(rst_n_in), .por_n_in(por_n_in), .stop_in(stop_in),
    .compare_out_pin_out(compare_out_pin_out), .irq_out(irq_out), .paddr_in(paddr_in),
    .psel_in(psel_in), .penable_in(penable_in), .prdata_out(prdata_out),
    .pready_out(pready_out), .pslverr_out(pslverr_out));

/* File: tb/tb.sv */
`timescale 1ns/1ps
`include "cct_map.svh"
module tb;
    localparam logic [7:0] a_ctrl = `CCT_IDX_CTRL << 2, a_stat = `CCT_IDX_STATUS << 2;
    localparam logic [7:0] a_caph = `CCT_IDX_CAP_HIGH << 2, a_capl = `CCT_IDX_CAP_LOW << 2;
    localparam logic [7:0] a_cmph = `CCT_IDX_CMP_HIGH << 2, a_cmpl = `CCT_IDX_CMP_LOW << 2;
    localparam logic [7:0] a_cnth = `CCT_IDX_CNT_HIGH << 2, a_cntl = `CCT_IDX_CNT_LOW << 2;
    localparam logic [7:0] a_alth = `CCT_IDX_ALT_HIGH << 2, a_altl = `CCT_IDX_ALT_LOW << 2;
    logic        clk, rst_n, por_n, stop, level, psel, penable, pwrite;
    logic [7:0]  paddr, toggles;
    logic [31:0] pwdata, prdata;
    logic        pready, pslverr, cmp_pin, irq, cap_pin;
    int          n_fail = 0;
    int          check_count = 0;

    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    cct_timer #(.ADDR_W(8)) u_cct_timer (.mclk_in(clk), .rst_n_in(rst_n), .por_n_in(por_n),
        .stop_in(stop), .capture_in_pin_in(cap_pin), .compare_out_pin_out(cmp_pin), .irq_out(irq),
        .paddr_in(paddr), .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
        .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr));
    cct_pin_model u_cct_pin_model (.mclk_in(clk), .level_in(level), .compare_pin_in(cmp_pin),
        .capture_pin_out(cap_pin), .toggles_out(toggles));

    task automatic final_report;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : final_report

    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // one apb transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d,
                       output logic [7:0] q, output logic e);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        // no cycle count is assumed; only the watchdog ends a hang
        do
        begin
            @(posedge clk);
        end
        while (pready !== 1'b1);
        q = prdata[7:0];
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        logic       e;
        apb(1'b1, a, d, q, e);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        logic e;
        apb(1'b0, a, 8'h00, q, e);
    endtask : rd

    // high first so the low byte is the latched one
    task automatic rd_cnt(output logic [15:0] v);
        rd(a_cnth, v[15:8]);
        rd(a_cntl, v[7:0]);
    endtask : rd_cnt

    task automatic rst_pulse;
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
    endtask : rst_pulse

    task automatic t_ovf;
        logic [7:0] q;
        int         n;
        wr(a_ctrl, 8'h22);
        for (n = 0; n < 100 && irq !== 1'b1; n++) @(posedge clk);
        rd(a_stat, q);
        chk("ovf_flag", 16'h1, q[5]);
        rd(a_alth, q);
        rd(a_altl, q);
        rd(a_stat, q);
        chk("ovf_after_alt", 16'h1, q[5]);
        rd(a_cntl, q);
        rd(a_stat, q);
        chk("ovf_cleared", 16'h0, q[5]);
        chk("irq_ovf_clear", 16'h0, irq);
        rst_pulse();
        rd(a_ctrl, q);
        chk("ctrl_after_rst", 16'h02, q & 8'he3);
        repeat (40) @(posedge clk);
        rd(a_stat, q);
        chk("ovf_rewrap", 16'h1, q[5]);
        chk("irq_ovf_masked", 16'h0, irq);
        rst_pulse();
        rd(a_stat, q);
        chk("ovf_kept_rst", 16'h1, q[5]);
    endtask : t_ovf

    task automatic t_count;
        logic [15:0] a, b, c;
        logic [7:0]  q;
        rd_cnt(a);
        repeat (32) @(posedge clk);
        rd_cnt(b);
        chk("tick_rate", a + 16'd10, b);
        rd_cnt(a);
        wr(a_cnth, 8'h00);
        wr(a_cntl, 8'h00);
        rd_cnt(b);
        chk("cnt_write_ignored", a + 16'd4, b);
        @(posedge clk);
        stop <= 1'b1;
        rd_cnt(a);
        level <= 1'b1;
        repeat (20) @(posedge clk);
        rd_cnt(b);
        chk("stop_hold", a, b);
        // an edge in stop only arms the capture; the flag waits for a wake-up
        rd(a_stat, q);
        chk("stop_cap_quiet", 16'h0, q[7]);
        stop <= 1'b0;
        rd(a_stat, q);
        chk("stop_cap_wake", 16'h1, q[7]);
        rd(a_caph, c[15:8]);
        rd(a_capl, c[7:0]);
        chk("stop_cap_value", a, c);
        // falling edge is not active here; let it settle before ctrl changes
        level <= 1'b0;
        repeat (8) @(posedge clk);
    endtask : t_count

    task automatic t_compare;
        logic [15:0] v;
        logic [7:0]  q, t0;
        int          n;
        wr(a_ctrl, 8'h41);
        // a wrap through zero matched the reset compare value; clear that stale flag
        rd(a_stat, q);
        rd(a_cmpl, q);
        rd(a_stat, q);
        chk("cmp_flag_pre", 16'h0, q[6]);
        rd_cnt(v);
        v = v + 16'd30;
        wr(a_cmph, v[15:8]);
        wr(a_cmpl, v[7:0]);
        for (n = 0; n < 400 && cmp_pin !== 1'b1; n++) @(posedge clk);
        chk("pin_high", 16'h1, cmp_pin);
        chk("irq_cmp", 16'h1, irq);
        rd(a_stat, q);
        chk("cmp_flag", 16'h1, q[6]);
        rd(a_cmpl, q);
        rd(a_stat, q);
        chk("cmp_cleared", 16'h0, q[6]);
        // low then high leaves a real match value, yet compares stay off
        wr(a_ctrl, 8'h40);
        rd_cnt(v);
        v = v + 16'd30;
        wr(a_cmpl, v[7:0]);
        wr(a_cmph, v[15:8]);
        t0 = toggles;
        repeat (200) @(posedge clk);
        chk("inhibit_pin", t0, toggles);
        rd(a_stat, q);
        chk("inhibit_flag", 16'h0, q[6]);
        rd_cnt(v);
        v = v + 16'd30;
        wr(a_cmph, v[15:8]);
        wr(a_cmpl, v[7:0]);
        for (n = 0; n < 400 && cmp_pin !== 1'b0; n++) @(posedge clk);
        chk("pin_low", 16'h0, cmp_pin);
    endtask : t_compare

    task automatic t_capture;
        logic [15:0] a, b, c;
        logic [7:0]  q;
        wr(a_ctrl, 8'h82);
        rd_cnt(a);
        level <= 1'b1;
        repeat (8) @(posedge clk);
        rd_cnt(b);
        chk("irq_cap", 16'h1, irq);
        rd(a_stat, q);
        chk("cap_flag", 16'h1, q[7]);
        rd(a_caph, c[15:8]);
        level <= 1'b0;
        repeat (8) @(posedge clk);
        level <= 1'b1;
        repeat (8) @(posedge clk);
        rd(a_capl, c[7:0]);
        chk("cap_value", 16'h1, c >= a && c <= b);
        wr(a_ctrl, 8'h00);
        rd(a_stat, q);
        rd(a_capl, q);
        level <= 1'b0;
        repeat (8) @(posedge clk);
        rd(a_stat, q);
        chk("cap_fall", 16'h1, q[7]);
        chk("irq_cap_masked", 16'h0, irq);
        rd(a_capl, q);
        level <= 1'b1;
        repeat (8) @(posedge clk);
        rd(a_stat, q);
        chk("cap_rise_ignored", 16'h0, q[7]);
    endtask : t_capture

    task automatic t_regs;
        logic [7:0] q;
        logic       e;
        wr(a_ctrl, 8'he3);
        rd(a_ctrl, q);
        chk("ctrl_rw", 16'he3, q & 8'he3);
        apb(1'b0, 8'h04, 8'h00, q, e);
        chk("unmapped_err", 16'h1, e);
        apb(1'b0, a_ctrl, 8'h00, q, e);
        chk("mapped_ok", 16'h0, e);
    endtask : t_regs

    // main sequence; both resets held four cycles
    initial
    begin
        rst_n = 1'b0;
        por_n = 1'b0;
        stop = 1'b0;
        level = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        por_n <= 1'b1;
        t_ovf();
        t_count();
        t_compare();
        t_capture();
        t_regs();
        final_report();
    end

    // cuts a hang; the whole run needs under a thousand cycles
    initial
    begin
        repeat (20000) @(posedge clk);
        n_fail++;
        final_report();
    end
endmodule : tb
